//--- inc/aes_pkg.sv
// Register map, source indices, action codes and helpers for the alarm supervisor
package aes_pkg;
  localparam int MEAS_W = 16;
  localparam int NUM_LIM = 3;
  localparam int NUM_EV = 3;
  localparam int NUM_DEV = 6;
  localparam int NUM_SRC = 9;
  localparam int NUM_ANA = 5;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VLIMIT = 8'h04;
  localparam logic [7:0] OFS_CLIMIT = 8'h08;
  localparam logic [7:0] OFS_PLIMIT = 8'h0c;
  localparam logic [7:0] OFS_EVACT = 8'h10;
  localparam logic [7:0] OFS_EVTHR_V = 8'h14;
  localparam logic [7:0] OFS_EVTHR_C = 8'h18;
  localparam logic [7:0] OFS_EVTHR_P = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_ACK = 8'h24;
  localparam logic [7:0] OFS_SELECT = 8'h28;
  localparam logic [7:0] OFS_NOM_V = 8'h2c;
  localparam logic [7:0] OFS_NOM_C = 8'h30;
  localparam logic [7:0] OFS_NOM_P = 8'h34;

  // Control register fields
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_SOUND_BIT = 1;
  localparam int CTRL_PF_RESTORE_BIT = 2;
  localparam int CTRL_OT_RESTORE_BIT = 3;
  localparam logic CTRL_SOUND_RESET = 1'h0;
  localparam logic CTRL_PF_RESTORE_RESET = 1'h0;
  localparam logic CTRL_OT_RESTORE_RESET = 1'h0;

  // Status register fields: pending at [8:0], shown at [24:16]
  localparam int STAT_PENDING_LSB = 0;
  localparam int STAT_SHOWN_LSB = 16;
  localparam int STAT_REFUSED_BIT = 12;
  localparam int STAT_DC_BIT = 31;

  // Event action field: two bits per event, event k at [2k+1:2k]
  localparam int EVACT_W = 2;

  // Source indices
  localparam int SRC_VTRIP = 0;
  localparam int SRC_CTRIP = 1;
  localparam int SRC_PTRIP = 2;
  localparam int SRC_PF = 3;
  localparam int SRC_OT = 4;
  localparam int SRC_LINK = 5;
  localparam int SRC_EV0 = 6;

  // Action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SIGNAL = 2'h1;
  localparam logic [1:0] ACT_WARNING = 2'h2;
  localparam logic [1:0] ACT_ALARM = 2'h3;
  localparam logic [2*NUM_EV-1:0] EVACT_RESET = 6'h00;

  // Protection limit ceiling and default: 110 % of nominal
  localparam logic [3:0] LIMIT_NUM = 4'hb;
  localparam logic [3:0] LIMIT_DEN = 4'ha;

  function automatic logic [MEAS_W-1:0] aes_pct110(input logic [MEAS_W-1:0] nom);
    logic [MEAS_W+3:0] wide;
    wide = ({4'h0, nom} * {{MEAS_W{1'b0}}, LIMIT_NUM}) / {{MEAS_W{1'b0}}, LIMIT_DEN};
    return wide[MEAS_W-1:0];
  endfunction

  function automatic logic [MEAS_W-1:0] aes_clamp(input logic [MEAS_W-1:0] v,
                                                  input logic [MEAS_W-1:0] top);
    return (v > top) ? top : v;
  endfunction
endpackage

//--- sim/aes_checker.sv
// Port-level assertion checker for the alarm supervisor
`timescale 1ns/1ps
module aes_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic supply_ok,
  input wire logic temp_over,
  input wire logic link_reinit,
  input wire logic dc_output_en,
  input wire logic [aes_pkg::NUM_SRC-1:0] status_pending,
  input wire logic [aes_pkg::NUM_SRC-1:0] status_shown,
  input wire logic popup_warning,
  input wire logic popup_alarm,
  input wire logic buzzer,
  input wire logic [aes_pkg::NUM_ANA-1:0] analog_alarm
);
  import aes_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Link loss is left out of AST_STICKY, as reinit clears it; AST_LINK_HOLD lets the clear lag reinit by a cycle
  logic ack_wr;
  assign ack_wr = psel && penable && pwrite && paddr == OFS_ACK;
  AST_PF_OFF: assert property (!supply_ok |=> !dc_output_en)
    else $error("output on during supply fail");
  AST_OT_OFF: assert property (temp_over |=> !dc_output_en)
    else $error("output on during overheat");
  for (genvar i = 0; i < 6; i++) begin : g_trip
    AST_TRIP: assert property (
      $rose(status_shown[i]) |=> status_pending[i] && !dc_output_en)
      else $error("alarm did not latch and switch off");
  end
  AST_STICKY: assert property (!ack_wr |=>
    ((status_pending & $past(status_pending)) & 9'h1df) == ($past(status_pending) & 9'h1df))
    else $error("pending flag cleared without acknowledge");
  AST_LINK_HOLD: assert property (
    status_pending[5] && !link_reinit && !$past(link_reinit) |=> status_pending[5])
    else $error("link loss cleared without reinit");
  AST_EV_OFF: assert property (
    !dc_output_en |=> (status_pending[8:6] & ~$past(status_pending[8:6])) == 3'h0)
    else $error("event latched while output off");
  AST_ANALOG: assert property (analog_alarm == status_shown[4:0])
    else $error("analog alarm lines mismatch");
  AST_BUZZ_PULSE: assert property (buzzer |=> !buzzer)
    else $error("buzzer pulse longer than one cycle");
  AST_BUZZ_CAUSE: assert property (buzzer |-> popup_alarm || popup_warning)
    else $error("buzzer without pop-up");
  AST_POPUP: assert property (|status_pending[5:0] |-> popup_alarm)
    else $error("device alarm pending without pop-up");
endmodule
bind aes_supervisor aes_checker u_aes_checker (.clock, .rstn, .psel, .penable, .pwrite,
  .paddr, .supply_ok, .temp_over, .link_reinit, .dc_output_en, .status_pending,
  .status_shown, .popup_warning, .popup_alarm, .buzzer, .analog_alarm);

//--- sim/tb_top.sv
// Self-checking bench for the alarm supervisor
`timescale 1ns/1ps
module tb_top;
  import aes_pkg::*;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic supply_ok = 1, temp_over = 0, is_master = 0, link_ok = 1, link_reinit = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, dc_output_en, popup_warning, popup_alarm, buzzer, e;
  logic [MEAS_W-1:0] mv [3] = '{default: 16'h0};
  logic [NUM_SRC-1:0] status_pending, status_shown;
  logic [NUM_ANA-1:0] analog_alarm;
  int error_cnt = 0, samples_checked = 0, buz_cnt = 0, b;
  aes_supervisor u_aes_supervisor (.clock, .rstn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .meas_voltage(mv[0]), .meas_current(mv[1]),
    .meas_power(mv[2]), .supply_ok, .temp_over, .is_master, .link_ok, .link_reinit,
    .dc_output_en, .status_pending, .status_shown, .popup_warning, .popup_alarm,
    .buzzer, .analog_alarm);
  always #25 clock = ~clock;
  // Count pulses, since a one-cycle buzzer is easy to miss between checks
  // Sampled on the falling edge, away from the edge that launches the pulse
  always @(negedge clock) if (buzzer === 1'b1) buz_cnt <= buz_cnt + 1;
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, s, x);
    end
  endtask
  // Starts with an edge so back-to-back calls never assign psel twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t: no ready on APB transfer", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic s_defaults;
    rdc(OFS_VLIMIT, 32'h0000044c);
    rdc(OFS_CLIMIT, 32'h0000044c);
    rdc(OFS_PLIMIT, 32'h0000044c);
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1);
    wr(OFS_VLIMIT, 32'h0000ffff);
    rdc(OFS_VLIMIT, 32'h0000044c);
    for (int i = 0; i < 3; i++) wr(8'(OFS_VLIMIT + 4 * i), 32'h00000200);
  endtask
  task automatic s_trips;
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, 32'h3);
      b = buz_cnt;
      mv[i] <= 16'h0200;
      tick(4);
      chk(status_pending[i], 1);
      chk(dc_output_en, 0);
      chk(analog_alarm[i], 1);
      chk(buz_cnt - b, 1);
      wr(OFS_ACK, 32'h1 << i);
      tick(1);
      chk(status_shown[i], 1);
      wr(OFS_SELECT, 32'h1 << i);
      mv[i] <= 16'h0;
      tick(3);
      chk(status_pending[i], 1);
      wr(OFS_ACK, 32'h1 << i);
      tick(1);
      chk(status_pending[i], 0);
    end
  endtask
  task automatic s_refuse;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_VLIMIT, 32'h00000100);
    rdc(OFS_VLIMIT, 32'h00000200);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q[STAT_REFUSED_BIT], 1);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_ACK, 32'h00001000);
  endtask
  task automatic s_events;
    wr(OFS_EVTHR_V, 32'h00000064);
    for (int a = 0; a < 4; a++) begin
      wr(OFS_EVACT, 32'(a));
      wr(OFS_CTRL, 32'h3);
      b = buz_cnt;
      mv[0] <= 16'h0064;
      tick(4);
      chk(status_pending[SRC_EV0], a != 0);
      chk(popup_warning, a == 2);
      chk(popup_alarm, a == 3);
      chk(dc_output_en, a != 3);
      chk(buz_cnt - b, a >= 2);
      mv[0] <= 16'h0;
      wr(OFS_CTRL, 32'h2);
      wr(OFS_ACK, 32'h40);
    end
    mv[0] <= 16'h0064;
    tick(4);
    chk(status_pending[SRC_EV0], 0);
    mv[0] <= 16'h0;
  endtask
  task automatic s_restart;
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTRL, 32'(1 | ((k % 2) << (2 + k / 2))));
      supply_ok <= k >= 2;
      temp_over <= k >= 2;
      tick(4);
      chk(dc_output_en, 0);
      chk(status_pending[SRC_PF + k / 2], 1);
      supply_ok <= 1'b1;
      temp_over <= 1'b0;
      tick(6);
      chk(dc_output_en, k % 2);
      wr(OFS_ACK, 32'h18);
    end
  endtask
  task automatic s_link;
    wr(OFS_CTRL, 32'h1);
    is_master <= 1'b1;
    link_ok <= 1'b0;
    tick(4);
    chk(status_pending[SRC_LINK], 1);
    chk(dc_output_en, 0);
    chk(analog_alarm, 0);
    link_ok <= 1'b1;
    wr(OFS_ACK, 32'h20);
    tick(1);
    chk(status_pending[SRC_LINK], 1);
    link_reinit <= 1'b1;
    tick(1);
    link_reinit <= 1'b0;
    tick(2);
    chk(status_pending[SRC_LINK], 0);
  endtask
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    tick(2);
    rstn <= 1'b1;
    s_defaults();
    s_trips();
    s_refuse();
    s_events();
    s_restart();
    s_link();
    give_verdict();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #250000;
    error_cnt++;
    give_verdict();
  end
endmodule

//--- src/aes_flag.sv
// Sticky pending flag with acknowledge and reselect for one alarm or event source
`timescale 1ns/1ps
module aes_flag (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cond,
  input wire logic enable,
  input wire logic ack,
  input wire logic reselect,
  output logic rise,
  output logic pending,
  output logic shown
);
  typedef struct packed {
    logic prev;
    logic pending;
  } aes_flag_s;

  aes_flag_s state;
  aes_flag_s next_state;
  logic live;

  assign live = cond & enable;
  assign rise = live & ~state.prev;
  assign pending = state.pending;
  // Acknowledged but still active keeps its status shown
  assign shown = state.pending | live;

  always_comb begin
    next_state = state;
    next_state.prev = live;
    if (ack) begin
      next_state.pending = 1'b0;
    end
    if (reselect && shown) begin
      next_state.pending = 1'b1;
    end
    // Set wins over a same-cycle acknowledge
    if (rise) begin
      next_state.pending = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

//--- src/aes_outctl.sv
// DC output state with switch-off on trips and restart after supply fail or overheat
`timescale 1ns/1ps
module aes_outctl (
  input wire logic clock,
  input wire logic rstn,
  input wire logic on_req,
  input wire logic off_req,
  input wire logic trip,
  input wire logic pf_cond,
  input wire logic ot_cond,
  input wire logic pf_restore,
  input wire logic ot_restore,
  output logic dc_on
);
  typedef enum logic [1:0] {DC_OFF, DC_ON, DC_PF_WAIT, DC_OT_WAIT} aes_dc_e;
  typedef struct packed {
    aes_dc_e mode;
  } aes_outctl_s;

  aes_outctl_s state;
  aes_outctl_s next_state;

  assign dc_on = (state.mode == DC_ON);

  always_comb begin
    next_state = state;
    case (state.mode)
      DC_OFF: begin
        // Switch-on is refused while a hardware fault is present
        if (on_req && !pf_cond && !ot_cond) begin
          next_state.mode = DC_ON;
        end
      end
      DC_ON: begin
        if (pf_cond) begin
          next_state.mode = pf_restore ? DC_PF_WAIT : DC_OFF;
        end else if (ot_cond) begin
          next_state.mode = ot_restore ? DC_OT_WAIT : DC_OFF;
        end else if (trip || off_req) begin
          next_state.mode = DC_OFF;
        end
      end
      DC_PF_WAIT: begin
        if (trip || off_req) begin
          next_state.mode = DC_OFF;
        end else if (!pf_cond && !ot_cond) begin
          next_state.mode = DC_ON;
        end
      end
      DC_OT_WAIT: begin
        if (trip || off_req) begin
          next_state.mode = DC_OFF;
        end else if (!ot_cond && !pf_cond) begin
          next_state.mode = DC_ON;
        end
      end
      default: begin
        next_state.mode = DC_OFF;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state.mode <= DC_OFF;
    end else begin
      state <= next_state;
    end
  end
endmodule

//--- src/aes_supervisor.sv
// Alarm and event supervisor for a programmable DC supply, with APB register access
// Notes on behaviour
// - Event with action NONE is fully ignored.
// - SIGNAL action posts status indication only.
// - WARNING posts status, warning pop-up, optional buzzer.
// - ALARM posts status, pop-up, buzzer, forces output off.
// - Every alarm stays pending until acknowledged.
// - Voltage at limit trips, output off; limit at most 110%.
// - Current at limit trips, output off; limit at most 110%.
// - Power at limit trips, output off; limit at most 110%.
// - Bad or lost AC input trips, output off.
// - After supply fail, restart follows configurable setting.
// - Overheat trips and switches output off.
// - After cooling, output follows configurable setting.
// - Master losing any slave trips, output off.
// - Link loss cleared only by reinit; not analog.
// - Protection limits default to 110% of nominal.
// - One enable gates buzzer for alarms and events.
// - Reselecting a shown status re-raises its pop-up.
// - Device alarms go to status; all but link loss to analog pins.
// - Events evaluated only while output on.
`timescale 1ns/1ps
module aes_supervisor #(
  parameter logic [aes_pkg::MEAS_W-1:0] NOM_VOLTAGE = 16'h03e8,
  parameter logic [aes_pkg::MEAS_W-1:0] NOM_CURRENT = 16'h03e8,
  parameter logic [aes_pkg::MEAS_W-1:0] NOM_POWER = 16'h03e8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [aes_pkg::MEAS_W-1:0] meas_voltage,
  input wire logic [aes_pkg::MEAS_W-1:0] meas_current,
  input wire logic [aes_pkg::MEAS_W-1:0] meas_power,
  input wire logic supply_ok,
  input wire logic temp_over,
  input wire logic is_master,
  input wire logic link_ok,
  input wire logic link_reinit,
  output logic dc_output_en,
  output logic [aes_pkg::NUM_SRC-1:0] status_pending,
  output logic [aes_pkg::NUM_SRC-1:0] status_shown,
  output logic popup_warning,
  output logic popup_alarm,
  output logic buzzer,
  output logic [aes_pkg::NUM_ANA-1:0] analog_alarm
);
  import aes_pkg::*;

  typedef struct packed {
    logic sound_en;
    logic pf_restore;
    logic ot_restore;
    logic cfg_refused;
    logic [NUM_LIM-1:0][MEAS_W-1:0] limit;
    logic [NUM_EV-1:0][MEAS_W-1:0] ev_thr;
    logic [NUM_EV-1:0][EVACT_W-1:0] ev_act;
    logic buzzer;
    logic [31:0] prdata;
    logic pslverr;
  } aes_top_s;

  aes_top_s state;
  aes_top_s next_state;

  logic [NUM_LIM-1:0][MEAS_W-1:0] nominal;
  logic [NUM_LIM-1:0][MEAS_W-1:0] lim_max;
  logic [NUM_LIM-1:0][MEAS_W-1:0] meas;
  logic [NUM_SRC-1:0][EVACT_W-1:0] act;
  logic [NUM_SRC-1:0] cond;
  logic [NUM_SRC-1:0] enable;
  logic [NUM_SRC-1:0] ack;
  logic [NUM_SRC-1:0] reselect;
  logic [NUM_SRC-1:0] rise;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] shown;
  logic [NUM_SRC-1:0] is_alarm;
  logic [NUM_SRC-1:0] is_warning;
  logic [NUM_SRC-1:0] is_loud;
  logic setup;
  logic wr_access;
  logic ack_wr;
  logic sel_wr;
  logic ctrl_wr;
  logic on_req;
  logic off_req;
  logic trip;
  logic dc_on;

  assign nominal = {NOM_POWER, NOM_CURRENT, NOM_VOLTAGE};
  assign meas = {meas_power, meas_current, meas_voltage};

  // APB phases: zero wait states, read data captured during setup
  assign setup = psel & ~penable;
  assign pready = psel & penable;
  assign wr_access = psel & penable & pwrite;
  assign ack_wr = wr_access & (paddr == OFS_ACK);
  assign sel_wr = wr_access & (paddr == OFS_SELECT);
  assign ctrl_wr = wr_access & (paddr == OFS_CTRL);
  assign prdata = state.prdata;
  assign pslverr = pready & state.pslverr;

  // Writing the on bit requests a change only when it differs from the output
  assign on_req = ctrl_wr & pwdata[CTRL_ON_BIT] & ~dc_on;
  assign off_req = ctrl_wr & ~pwdata[CTRL_ON_BIT] & dc_on;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LIM; gi++) begin : g_lim
      assign lim_max[gi] = aes_pct110(nominal[gi]);
      // Protection trips once the measurement reaches its limit
      assign cond[SRC_VTRIP + gi] = (meas[gi] >= state.limit[gi]);
    end
    for (gi = 0; gi < NUM_EV; gi++) begin : g_ev
      assign cond[SRC_EV0 + gi] = (meas[gi] >= state.ev_thr[gi]);
      assign act[SRC_EV0 + gi] = state.ev_act[gi];
      // Events only look at the output while it is on
      assign enable[SRC_EV0 + gi] = dc_on & (state.ev_act[gi] != ACT_NONE);
    end
    for (gi = 0; gi < NUM_DEV; gi++) begin : g_dev
      assign act[gi] = ACT_ALARM;
      assign enable[gi] = 1'b1;
    end
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      assign reselect[gi] = sel_wr & pwdata[gi];
      assign is_alarm[gi] = (act[gi] == ACT_ALARM);
      assign is_warning[gi] = (act[gi] == ACT_WARNING);
      assign is_loud[gi] = is_alarm[gi] | is_warning[gi];
      aes_flag u_flag (
        .clock(clock),
        .rstn(rstn),
        .cond(cond[gi]),
        .enable(enable[gi]),
        .ack(ack[gi]),
        .reselect(reselect[gi]),
        .rise(rise[gi]),
        .pending(pending[gi]),
        .shown(shown[gi])
      );
    end
  endgenerate

  assign cond[SRC_PF] = ~supply_ok;
  assign cond[SRC_OT] = temp_over;
  assign cond[SRC_LINK] = is_master & ~link_ok;

  // Software acknowledges everything but link loss, which only a reinit clears
  always_comb begin
    ack = {NUM_SRC{ack_wr}} & pwdata[NUM_SRC-1:0];
    ack[SRC_LINK] = link_reinit;
  end

  // A new alarm-class trigger forces the output off
  assign trip = |(rise & is_alarm);

  aes_outctl u_outctl (
    .clock(clock),
    .rstn(rstn),
    .on_req(on_req),
    .off_req(off_req),
    .trip(trip),
    .pf_cond(cond[SRC_PF]),
    .ot_cond(cond[SRC_OT]),
    .pf_restore(state.pf_restore),
    .ot_restore(state.ot_restore),
    .dc_on(dc_on)
  );

  assign dc_output_en = dc_on;
  assign status_pending = pending;
  assign status_shown = shown;
  // SIGNAL events never reach a pop-up
  assign popup_warning = |(pending & is_warning);
  assign popup_alarm = |(pending & is_alarm);
  assign buzzer = state.buzzer;
  // Link loss is left off the analog pins
  assign analog_alarm = shown[NUM_ANA-1:0];

  always_comb begin
    next_state = state;
    // One-cycle buzzer pulse per new warning or alarm, gated by one enable
    next_state.buzzer = state.sound_en & |(rise & is_loud);

    if (wr_access) begin
      case (paddr)
        OFS_CTRL: begin
          next_state.pf_restore = pwdata[CTRL_PF_RESTORE_BIT];
          next_state.ot_restore = pwdata[CTRL_OT_RESTORE_BIT];
          if (dc_on) begin
            if (pwdata[CTRL_SOUND_BIT] != state.sound_en) begin
              next_state.cfg_refused = 1'b1;
            end
          end else begin
            next_state.sound_en = pwdata[CTRL_SOUND_BIT];
          end
        end
        OFS_VLIMIT, OFS_CLIMIT, OFS_PLIMIT: begin
          if (dc_on) begin
            next_state.cfg_refused = 1'b1;
          end else begin
            // Values above the ceiling are clamped rather than rejected
            next_state.limit[paddr[3:2] - 2'h1] =
              aes_clamp(pwdata[MEAS_W-1:0], lim_max[paddr[3:2] - 2'h1]);
          end
        end
        OFS_EVACT: begin
          if (dc_on) begin
            next_state.cfg_refused = 1'b1;
          end else begin
            next_state.ev_act = pwdata[2*NUM_EV-1:0];
          end
        end
        OFS_EVTHR_V, OFS_EVTHR_C, OFS_EVTHR_P: begin
          if (dc_on) begin
            next_state.cfg_refused = 1'b1;
          end else begin
            next_state.ev_thr[paddr[3:2] - 2'h1] = aes_clamp(pwdata[MEAS_W-1:0],
                                                            nominal[paddr[3:2] - 2'h1]);
          end
        end
        OFS_ACK: begin
          if (pwdata[STAT_REFUSED_BIT]) begin
            next_state.cfg_refused = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    if (setup) begin
      next_state.pslverr = 1'b0;
      next_state.prdata = '0;
      case (paddr)
        OFS_CTRL: begin
          next_state.prdata[CTRL_ON_BIT] = dc_on;
          next_state.prdata[CTRL_SOUND_BIT] = state.sound_en;
          next_state.prdata[CTRL_PF_RESTORE_BIT] = state.pf_restore;
          next_state.prdata[CTRL_OT_RESTORE_BIT] = state.ot_restore;
        end
        OFS_VLIMIT: next_state.prdata[MEAS_W-1:0] = state.limit[0];
        OFS_CLIMIT: next_state.prdata[MEAS_W-1:0] = state.limit[1];
        OFS_PLIMIT: next_state.prdata[MEAS_W-1:0] = state.limit[2];
        OFS_EVACT: next_state.prdata[2*NUM_EV-1:0] = state.ev_act;
        OFS_EVTHR_V: next_state.prdata[MEAS_W-1:0] = state.ev_thr[0];
        OFS_EVTHR_C: next_state.prdata[MEAS_W-1:0] = state.ev_thr[1];
        OFS_EVTHR_P: next_state.prdata[MEAS_W-1:0] = state.ev_thr[2];
        OFS_STATUS: begin
          next_state.prdata[STAT_PENDING_LSB +: NUM_SRC] = pending;
          next_state.prdata[STAT_SHOWN_LSB +: NUM_SRC] = shown;
          next_state.prdata[STAT_REFUSED_BIT] = state.cfg_refused;
          next_state.prdata[STAT_DC_BIT] = dc_on;
        end
        OFS_ACK, OFS_SELECT: begin
        end
        OFS_NOM_V: next_state.prdata[MEAS_W-1:0] = nominal[0];
        OFS_NOM_C: next_state.prdata[MEAS_W-1:0] = nominal[1];
        OFS_NOM_P: next_state.prdata[MEAS_W-1:0] = nominal[2];
        default: begin
          next_state.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= '0;
      state.sound_en <= CTRL_SOUND_RESET;
      state.pf_restore <= CTRL_PF_RESTORE_RESET;
      state.ot_restore <= CTRL_OT_RESTORE_RESET;
      state.limit <= lim_max;
      state.ev_act <= EVACT_RESET;
      state.ev_thr <= nominal;
    end else begin
      state <= next_state;
    end
  end
endmodule
